// ---- pkg/rbec_pkg.sv ----
// Constants, types and reset values shared by the reset, boot and error controller
package rbec_pkg;

   // ***************************************************************
   // Widths
   // ***************************************************************
   localparam int DW     = 32;                   // Register data width
   localparam int AW     = 8;                    // Register byte address width
   localparam int MAW    = 16;                   // Memory address width
   localparam int LINK_N = 4;                    // Number of serial links
   localparam int LSW    = $clog2(LINK_N);       // Link index width
   localparam int OPND_W = 16;                   // Index and bound halves of operand
   localparam int IRQ_N  = 4;                    // Interrupt sources

   // ***************************************************************
   // Register map (byte addresses)
   // ***************************************************************
   localparam logic [AW-1:0] A_CTRL  = 8'h00;    // Operation launch, last opcode
   localparam logic [AW-1:0] A_OPND  = 8'h04;    // Subscript check operand
   localparam logic [AW-1:0] A_STAT  = 8'h08;    // Sequencer and flag status
   localparam logic [AW-1:0] A_RES   = 8'h0c;    // Result of last test operation
   localparam logic [AW-1:0] A_IPTR  = 8'h10;    // Instruction pointer
   localparam logic [AW-1:0] A_WPTR  = 8'h14;    // Workspace pointer
   localparam logic [AW-1:0] A_ISTAT = 8'h18;    // Sticky event bits, write one clears
   localparam logic [AW-1:0] A_IMASK = 8'h1c;    // Event enable mask

   // ***************************************************************
   // Operation codes and their cycle counts
   // ***************************************************************
   localparam logic [7:0] OP_CSUB    = 8'h13;
   localparam logic [7:0] OP_TESTERR = 8'h29;
   localparam logic [7:0] OP_SETERR  = 8'h10;
   localparam logic [7:0] OP_STOPERR = 8'h55;
   localparam logic [7:0] OP_CLRHALT = 8'h57;
   localparam logic [7:0] OP_SETHALT = 8'h58;
   localparam logic [7:0] OP_TSTHALT = 8'h59;
   localparam logic [7:0] OP_SAVEH   = 8'h3e;
   localparam logic [7:0] OP_SAVEL   = 8'h3d;
   localparam logic [2:0] CY_ONE     = 3'h1;
   localparam logic [2:0] CY_TWO     = 3'h2;
   localparam logic [2:0] CY_THREE   = 3'h3;
   localparam logic [2:0] CY_FOUR    = 3'h4;
   localparam logic [2:0] CY_NONE    = 3'h0;     // Unknown opcode

   // ***************************************************************
   // Boot constants
   // ***************************************************************
   localparam logic [MAW-1:0] ROM_BOOT_ADDR  = 16'h7ffe;
   localparam logic [MAW-1:0] FIRST_FREE_DEF = 16'h0040;
   localparam logic [7:0]     CTRL_BYTE_MAX  = 8'h01;  // Above this a byte count follows
   localparam logic [7:0]     LAST_BYTE      = 8'h01;

   // Interrupt bit positions
   localparam int IRQ_BOOT = 0;
   localparam int IRQ_ERR  = 1;
   localparam int IRQ_DONE = 2;
   localparam int IRQ_EVT  = 3;

   // ***************************************************************
   // Types
   // ***************************************************************
   typedef enum logic [1:0] {
      BS_HOLD      = 2'h0,
      BS_LINK_WAIT = 2'h1,
      BS_LINK_LOAD = 2'h2,
      BS_RUN       = 2'h3
   } rbec_boot_e;

   typedef struct packed {
      logic [AW-1:0] addr;
      logic [DW-1:0] wdata;
      logic          we;
      logic          re;
   } rbec_bus_s;

   typedef struct packed {
      logic err;
      logic halt;
      logic trip;
   } rbec_err_s;

   typedef struct packed {
      rbec_boot_e       bst;
      logic             boot_rom;
      logic             fetch;
      logic             pri_low;
      logic             halted;
      logic             stopped;
      logic             busy;
      logic [7:0]       op;
      logic [2:0]       cnt;
      logic             result;
      logic [DW-1:0]    opnd;
      logic [MAW-1:0]   iptr;
      logic [MAW-1:0]   wptr;
      logic [MAW-1:0]   addr;
      logic [MAW-1:0]   maddr;
      logic [7:0]       count;
      logic [7:0]       mdata;
      logic [LSW-1:0]   lsel;
      logic [LINK_N-1:0] ack;
      logic             mwe;
      logic             ev_prev;
      logic [IRQ_N-1:0] istat;
      logic [IRQ_N-1:0] imask;
      logic             irq;
      logic [DW-1:0]    rdata;
   } rbec_state_s;

   localparam rbec_state_s RST_STATE = '{bst: BS_HOLD, pri_low: 1'b1, default: '0};

endpackage

// ---- hw/rbec_sync2.sv ----
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module rbec_sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   import rbec_pkg::*;

   logic [W-1:0] meta_q;

   // No reset: the pins must be tracked while the device is held in reset
   always_ff @(posedge clk_i) begin
      meta_q <= d_i;
      q_o    <= meta_q;
   end

endmodule // rbec_sync2

// ---- hw/rbec_err_flags.sv ----
// Error and halt-when-faulted flags, kept across the device reset
`timescale 1ns/10ps
module rbec_err_flags (
   input  wire logic clk_i,
   input  wire logic pwr_rst_i,
   input  wire logic set_i,
   input  wire logic clr_i,
   input  wire logic halt_set_i,
   input  wire logic halt_clr_i,
   output logic      err_o,
   output logic      halt_o,
   output logic      trip_o
);
   import rbec_pkg::*;

   rbec_err_s s, n;

   // Set wins over clear so a fault in the clearing cycle survives
   always_comb begin
      n      = s;
      n.err  = set_i | (s.err & ~clr_i);
      n.halt = halt_set_i | (s.halt & ~halt_clr_i);
      n.trip = set_i & ~s.err & s.halt;   // Only a 0 to 1 change under halt trips
   end

   // Of the two resets only power-on clears these; the device reset leaves them for analysis
   always_ff @(posedge clk_i or posedge pwr_rst_i) begin
      if (pwr_rst_i) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign err_o  = s.err;
   assign halt_o = s.halt;
   assign trip_o = s.trip;

endmodule // rbec_err_flags

// ---- hw/rbec_ctrl.sv ----
// Reset, bootstrap sequencing and error-flag operation engine
//
// Summary of operation
// RULE1: Start boot sequencing after reset release
// RULE2: Link outputs held low during reset
// RULE3: Partner keeps link and event inputs low
// RULE4: No memory requests while reset high
// RULE5: Select pin picks ROM or link boot
// RULE6: Run at low priority after reset
// RULE7: Sample boot select once, then ignore
// RULE8: ROM boot starts at top address
// RULE9: ROM boot sets workspace to first free
// RULE10: Partner supplies nominal 5 MHz reference clock
// RULE11: Reference clock runs 10 ms before release
// RULE12: Test-and-clear error: inverted result, 2/3 cycles
// RULE13: Stop-on-error takes 2 cycles, deschedules
// RULE14: Subscript check: 2 cycles, may set error
// RULE15: Queue save operations take 4 cycles
// RULE16: Reset leaves error flag unchanged
// RULE17: Control byte above one loads bytes
// RULE18: Fetch and links idle during reset
`timescale 1ns/10ps
module rbec_ctrl #(
   parameter logic [15:0] FIRST_FREE = 16'h0040
) (
   input  wire logic                    clk_i,
   input  wire logic                    rst_i,
   input  wire logic                    pwr_rst_i,
   input  wire rbec_pkg::rbec_bus_s     bus_i,
   output logic [rbec_pkg::DW-1:0]      rdata_o,
   output logic                         irq_o,
   input  wire logic                    boot_source_select_i,
   input  wire logic                    event_request_input_i,
   input  wire logic [rbec_pkg::LINK_N-1:0]      link_rx_valid_i,
   input  wire logic [rbec_pkg::LINK_N-1:0][7:0] link_rx_data_i,
   output logic [rbec_pkg::LINK_N-1:0]  link_ack_o,
   output logic                         mem_we_o,
   output logic [rbec_pkg::MAW-1:0]     mem_addr_o,
   output logic [7:0]                   mem_wdata_o,
   output logic                         fetch_en_o,
   output logic                         pri_low_o,
   output logic                         error_o,
   output logic                         halted_o
);
   import rbec_pkg::*;

   // ***************************************************************
   // Declarations
   // ***************************************************************
   rbec_state_s      s, n;
   logic [1:0]       pins_s;
   logic             boot_s, evt_s;
   logic             err, halt, trip;
   logic             err_set, err_clr, halt_set, halt_clr;
   logic             launch;
   logic [2:0]       cyc;
   logic [IRQ_N-1:0] ev_set, w1c;
   logic             hit;
   logic [LSW-1:0]   hsel;

   // Cycle count of each supported operation, zero when unknown
   function automatic logic [2:0] op_cycles(input logic [7:0] op, input logic e);
      logic [2:0] c;
      c = CY_NONE;
      case (op)
         OP_TESTERR: c = e ? CY_THREE : CY_TWO;       // [RULE12]
         OP_STOPERR: c = CY_TWO;                      // [RULE13]
         OP_CSUB:    c = CY_TWO;                      // [RULE14]
         OP_SAVEH,
         OP_SAVEL:   c = CY_FOUR;                     // [RULE15]
         OP_SETERR,
         OP_CLRHALT,
         OP_SETHALT: c = CY_ONE;
         OP_TSTHALT: c = CY_TWO;
         default:    c = CY_NONE;
      endcase
      return c;
   endfunction

   // ***************************************************************
   // Pin synchronisers and flags
   // ***************************************************************
   rbec_sync2 #(
      .W (2)
   ) u_sync (
      .clk_i (clk_i),
      .d_i   ({boot_source_select_i, event_request_input_i}),
      .q_o   (pins_s)
   );
   assign boot_s = pins_s[1];
   assign evt_s  = pins_s[0];

   // Flags live on the power-on reset only, so rst_i cannot disturb them
   rbec_err_flags u_err (
      .clk_i      (clk_i),
      .pwr_rst_i  (pwr_rst_i),
      .set_i      (err_set),
      .clr_i      (err_clr),
      .halt_set_i (halt_set),
      .halt_clr_i (halt_clr),
      .err_o      (err),                             // [RULE16]
      .halt_o     (halt),
      .trip_o     (trip)
   );

   // ***************************************************************
   // Next-state logic
   // ***************************************************************
   always_comb begin
      n        = s;
      err_set  = 1'b0;
      err_clr  = 1'b0;
      halt_set = 1'b0;
      halt_clr = 1'b0;
      ev_set   = '0;
      w1c      = '0;
      hit      = 1'b0;
      hsel     = '0;
      n.ack    = '0;
      n.mwe    = 1'b0;
      n.rdata  = '0;
      n.ev_prev = evt_s;
      cyc      = op_cycles(bus_i.wdata[7:0], err);
      launch   = bus_i.we && (bus_i.addr == A_CTRL) && !s.busy && (cyc != CY_NONE);

      // Boot sequencer; reset holds it in BS_HOLD with links and fetch idle
      unique case (s.bst)
         BS_HOLD: begin
            n.boot_rom = boot_s;                                 // [RULE7]
            if (boot_s) begin
               n.bst   = BS_RUN;                                 // [RULE5] [RULE1]
               n.iptr  = ROM_BOOT_ADDR;                          // [RULE8]
               n.wptr  = FIRST_FREE;                             // [RULE9]
               n.fetch = 1'b1;
               ev_set[IRQ_BOOT] = 1'b1;
            end else begin
               n.bst = BS_LINK_WAIT;                             // [RULE5] [RULE1]
            end
         end
         BS_LINK_WAIT: begin
            // Lowest link number wins if several offer a control byte at once
            for (int i = LINK_N - 1; i >= 0; i--) begin
               if (link_rx_valid_i[i] && (link_rx_data_i[i] > CTRL_BYTE_MAX)) begin
                  hit  = 1'b1;
                  hsel = LSW'(i);
               end
            end
            if (hit) begin
               n.lsel      = hsel;
               n.count     = link_rx_data_i[hsel];               // [RULE17]
               n.addr      = FIRST_FREE;
               n.ack[hsel] = 1'b1;
               n.bst       = BS_LINK_LOAD;
            end
         end
         BS_LINK_LOAD: begin
            // Bytes from other links are left for their own receivers
            if (link_rx_valid_i[s.lsel]) begin
               n.ack[s.lsel] = 1'b1;
               n.mwe   = 1'b1;                                   // [RULE17]
               n.maddr = s.addr;
               n.mdata = link_rx_data_i[s.lsel];
               n.addr  = s.addr + 16'h0001;
               n.count = s.count - 8'h01;
               if (s.count == LAST_BYTE) begin
                  n.bst   = BS_RUN;
                  n.iptr  = FIRST_FREE;
                  n.wptr  = s.addr + 16'h0001;   // Workspace sits above the code
                  n.fetch = 1'b1;
                  ev_set[IRQ_BOOT] = 1'b1;
               end
            end
         end
         BS_RUN: begin
            n.fetch = !(s.halted || trip);
         end
      endcase

      // A fault raised under the halt flag stops the processor until reset
      if (trip) begin
         n.halted = 1'b1;
      end

      // Operation engine: busy for exactly the operation's cycle count
      if (s.busy) begin
         if (s.cnt == CY_NONE) begin
            n.busy = 1'b0;
            ev_set[IRQ_DONE] = 1'b1;
            case (s.op)
               OP_TESTERR: begin
                  n.result = !err;                               // [RULE12]
                  err_clr  = 1'b1;                               // [RULE16]
               end
               OP_CSUB: begin
                  err_set = s.opnd[OPND_W-1:0] >= s.opnd[DW-1:OPND_W]; // [RULE14]
               end
               OP_STOPERR: begin
                  n.stopped = s.stopped | err;                   // [RULE13]
               end
               OP_SETERR:  err_set  = 1'b1;
               OP_SETHALT: halt_set = 1'b1;
               OP_CLRHALT: halt_clr = 1'b1;
               OP_TSTHALT: n.result = halt;
               default: ;
            endcase
         end else begin
            n.cnt = s.cnt - 3'h1;
         end
      end else if (launch) begin
         n.busy = 1'b1;                                          // [RULE15]
         n.op   = bus_i.wdata[7:0];
         n.cnt  = cyc - 3'h1;
      end
      if (err_set && !err) begin
         ev_set[IRQ_ERR] = 1'b1;
      end
      if (evt_s && !s.ev_prev) begin
         ev_set[IRQ_EVT] = 1'b1;
      end

      // Register writes; sticky bits are cleared by writing ones
      if (bus_i.we) begin
         case (bus_i.addr)
            A_OPND:  n.opnd  = bus_i.wdata;
            A_IMASK: n.imask = bus_i.wdata[IRQ_N-1:0];
            A_ISTAT: w1c     = bus_i.wdata[IRQ_N-1:0];
            default: ;
         endcase
      end
      n.istat = (s.istat & ~w1c) | ev_set;      // New events win over the clear
      n.irq   = |(n.istat & n.imask);

      // Read data stands only in the cycle after the strobe
      if (bus_i.re) begin
         case (bus_i.addr)
            A_CTRL:  n.rdata = DW'(s.op);
            A_OPND:  n.rdata = s.opnd;
            A_STAT:  n.rdata = DW'({s.bst, s.boot_rom, s.fetch, s.pri_low, s.busy,
                                    s.stopped, s.halted, halt, err});
            A_RES:   n.rdata = DW'(s.result);
            A_IPTR:  n.rdata = DW'(s.iptr);
            A_WPTR:  n.rdata = DW'(s.wptr);
            A_ISTAT: n.rdata = DW'(s.istat);
            A_IMASK: n.rdata = DW'(s.imask);
            default: n.rdata = '0;
         endcase
      end
   end

   // ***************************************************************
   // State register
   // ***************************************************************
   // Reset returns everything except the error flags to its initial state
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s <= RST_STATE;                                         // [RULE2] [RULE6] [RULE18]
      end else begin
         s <= n;
      end
   end

   // Outputs straight from flops
   assign rdata_o     = s.rdata;
   assign irq_o       = s.irq;
   assign link_ack_o  = s.ack;
   assign mem_we_o    = s.mwe;
   assign mem_addr_o  = s.maddr;
   assign mem_wdata_o = s.mdata;
   assign fetch_en_o  = s.fetch;
   assign pri_low_o   = s.pri_low;
   assign error_o     = err;
   assign halted_o    = s.halted;

   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i || pwr_rst_i);

   a_leave_hold: assert property (s.bst == BS_HOLD |=> s.bst != BS_HOLD) // [RULE1]
      else $error("sequencer stayed in hold after reset");
   a_link_low_rst: assert property (@(posedge clk_i) disable iff (pwr_rst_i) // [RULE2]
      rst_i |-> (link_ack_o == '0) && !mem_we_o)
      else $error("link output active during reset");
   a_rom_path: assert property (s.bst == BS_HOLD && boot_s |=> // [RULE5]
      s.bst == BS_RUN && fetch_en_o && s.iptr == ROM_BOOT_ADDR)
      else $error("rom boot not started");
   a_link_path: assert property (s.bst == BS_HOLD && !boot_s |=> // [RULE5]
      s.bst == BS_LINK_WAIT && !fetch_en_o)
      else $error("link boot wait not entered");
   a_low_pri: assert property (pri_low_o) // [RULE6]
      else $error("priority not low");
   a_sample_once: assert property (s.bst != BS_HOLD |=> $stable(s.boot_rom)) // [RULE7]
      else $error("boot select resampled");
   a_rom_wptr: assert property (s.bst == BS_RUN && s.boot_rom |-> // [RULE8]
      s.wptr == FIRST_FREE) // [RULE9]
      else $error("rom boot workspace wrong");
   a_testerr_set: assert property (launch && bus_i.wdata[7:0] == OP_TESTERR && err // [RULE12]
      |=> s.busy [*3] ##1 (!s.busy && !err && s.result == 1'b0))
      else $error("test error with fault wrong");
   a_testerr_clr: assert property (launch && bus_i.wdata[7:0] == OP_TESTERR && !err // [RULE12]
      |=> s.busy [*2] ##1 (!s.busy && s.result))
      else $error("test error without fault wrong");
   a_stoperr_time: assert property (launch && bus_i.wdata[7:0] == OP_STOPERR // [RULE13]
      |=> s.busy [*2] ##1 !s.busy)
      else $error("stop on error timing wrong");
   a_csub_fail: assert property (launch && bus_i.wdata[7:0] == OP_CSUB && // [RULE14]
      s.opnd[OPND_W-1:0] >= s.opnd[DW-1:OPND_W] && !(bus_i.we && bus_i.addr == A_OPND)
      |=> s.busy [*2] ##1 err)
      else $error("subscript check did not fault");
   a_save_time: assert property (launch && (bus_i.wdata[7:0] == OP_SAVEH || // [RULE15]
      bus_i.wdata[7:0] == OP_SAVEL) |=> s.busy [*4] ##1 !s.busy)
      else $error("queue save timing wrong");
   a_err_rst: assert property (@(posedge clk_i) disable iff (pwr_rst_i) // [RULE16]
      rst_i && $past(rst_i) |-> $stable(error_o))
      else $error("reset altered error flag");
   a_load_write: assert property (s.bst == BS_LINK_LOAD && link_rx_valid_i[s.lsel] // [RULE17]
      |=> mem_we_o && mem_addr_o == $past(s.addr))
      else $error("boot byte not written");
   a_hold_idle: assert property (s.bst != BS_RUN |-> !fetch_en_o) // [RULE18]
      else $error("fetch active before boot");

   // Boot hand-over and error flag lifetime; a stray clear would hide a faulty unit
   a_link_end: assert property (s.bst == BS_LINK_LOAD && link_rx_valid_i[s.lsel] && // [RULE17]
      s.count == LAST_BYTE |=> fetch_en_o && s.iptr == FIRST_FREE &&
      s.wptr == $past(s.addr) + 16'h0001)
      else $error("link boot end state wrong");
   a_err_clear_only: assert property ($fell(error_o) |-> // [RULE16]
      $past(s.busy && s.op == OP_TESTERR && s.cnt == CY_NONE))
      else $error("error flag cleared by other cause");
   a_stop_flag: assert property (launch && bus_i.wdata[7:0] == OP_STOPERR && err // [RULE13]
      |=> s.busy [*2] ##1 s.stopped)
      else $error("stop on error did not stop");
   a_halt_trip: assert property (trip |=> halted_o && !fetch_en_o)
      else $error("fault under halt flag did not halt");

   // Main scenarios, to show that the bench reaches them
   c_rom_boot:  cover property (s.bst == BS_HOLD && boot_s ##1 s.bst == BS_RUN);
   c_link_boot: cover property (s.bst == BS_LINK_LOAD ##1 s.bst == BS_RUN);
   c_testerr:   cover property (s.busy && s.op == OP_TESTERR && err);
   c_halted:    cover property (trip ##1 halted_o);
   c_csub_bad:  cover property (s.busy && s.op == OP_CSUB ##1 !s.busy && err);

endmodule // rbec_ctrl

// ---- sim/rbec_link_host.sv ----
// Link boot host model: sends a control byte and a boot image on one link
`timescale 1ns/10ps
module rbec_link_host #(
   parameter int LINK = 1
) (
   input  wire logic                             clk_i,
   input  wire logic                             rst_i,
   input  wire logic [rbec_pkg::LINK_N-1:0]      ack_i,
   output logic      [rbec_pkg::LINK_N-1:0]      valid_o,
   output logic      [rbec_pkg::LINK_N-1:0][7:0] data_o
);
   import rbec_pkg::*;

   // Idle links start low
   initial begin
      valid_o = '0;
      data_o  = '0;
   end

   // Device in reset sees quiet link inputs
   always @(posedge rst_i) valid_o <= '0;

   // One byte: single-cycle strobe, then wait for the acknowledge pulse
   task automatic put(input logic [7:0] b, input int gap);
      int n;
      n = 0;
      repeat (gap) @(posedge clk_i);
      @(posedge clk_i);
      valid_o[LINK] <= 1'h1;
      data_o[LINK]  <= b;
      @(posedge clk_i);
      valid_o[LINK] <= 1'h0;
      data_o[LINK]  <= ~b;   // Released line must not keep the old byte
      #1;
      while (ack_i[LINK] !== 1'h1 && n < 16) begin
         @(posedge clk_i);
         #1;
         n++;
      end
   endtask

   // Control byte above one gives the image length; gap slows the host
   task automatic send(input logic [7:0] count, input int gap);
      put(count, gap);
      for (int k = 0; k < count; k++) put(8'ha0 + 8'(k), gap);
   endtask
endmodule // rbec_link_host

// ---- sim/rbec_ctrl_tb.sv ----
// Self-checking testbench for the reset, boot and error controller
`timescale 1ns/10ps
module rbec_ctrl_tb;
   import rbec_pkg::*;
   localparam logic [15:0] FF = 16'h0100;
   typedef struct {
      logic [7:0]  op;
      logic [31:0] opnd;
      int          cyc;
      logic        err;
      logic [1:0]  res;  // Bit 1 asks for a result check, bit 0 holds it
   } rbec_row_s;
   logic                   clk, rst, pwr_rst, irq, bsel, ev, mwe, fetch, pri, err, halted;
   rbec_bus_s              bus;
   logic [DW-1:0]          rdata, d;
   logic [LINK_N-1:0]      lvalid, lack;
   logic [LINK_N-1:0][7:0] ldata;
   logic [MAW-1:0]         maddr, last_a;
   logic [7:0]             mdata, last_d;
   int                     failures, checks, nwr, n;
   rbec_row_s rows[14] = '{
      '{OP_CSUB, 32'h0009_0005, 2, 1'h0, 2'h0}, '{OP_CSUB, 32'h0009_0009, 2, 1'h1, 2'h0},
      '{OP_TESTERR, 32'h0, 3, 1'h0, 2'h2}, '{OP_TESTERR, 32'h0, 2, 1'h0, 2'h3},
      '{OP_STOPERR, 32'h0, 2, 1'h0, 2'h0}, '{OP_SAVEH, 32'h0, 4, 1'h0, 2'h0},
      '{OP_SAVEL, 32'h0, 4, 1'h0, 2'h0}, '{OP_SETERR, 32'h0, 1, 1'h1, 2'h0},
      '{OP_STOPERR, 32'h0, 2, 1'h1, 2'h0},
      '{OP_TESTERR, 32'h0, 3, 1'h0, 2'h2}, '{OP_SETHALT, 32'h0, 1, 1'h0, 2'h0},
      '{OP_TSTHALT, 32'h0, 2, 1'h0, 2'h3}, '{OP_CLRHALT, 32'h0, 1, 1'h0, 2'h0},
      '{OP_TSTHALT, 32'h0, 2, 1'h0, 2'h2}};

   rbec_ctrl #(.FIRST_FREE(FF)) i_rbec_ctrl (
      .clk_i(clk), .rst_i(rst), .pwr_rst_i(pwr_rst), .bus_i(bus), .rdata_o(rdata),
      .irq_o(irq), .boot_source_select_i(bsel), .event_request_input_i(ev),
      .link_rx_valid_i(lvalid), .link_rx_data_i(ldata), .link_ack_o(lack),
      .mem_we_o(mwe), .mem_addr_o(maddr), .mem_wdata_o(mdata), .fetch_en_o(fetch),
      .pri_low_o(pri), .error_o(err), .halted_o(halted));

   rbec_link_host #(.LINK(1)) i_rbec_link_host (
      .clk_i(clk), .rst_i(rst), .ack_i(lack), .valid_o(lvalid), .data_o(ldata));

   // 200 MHz clock, standing in for the derived core clock
   always #2.5 clk = ~clk;

   // Values sampled at the edge are the ones that stood in the ending cycle
   always @(posedge clk) begin
      if (mwe === 1'h1) begin
         nwr++;
         last_a = maddr;
         last_d = mdata;
      end
   end

   // Comparison, counted; four-state so an unknown never matches
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
      @(posedge clk);
      bus.we    <= 1'h1;
      bus.addr  <= a;
      bus.wdata <= v;
      @(posedge clk);
      bus.we    <= 1'h0;
   endtask

   task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] v);
      @(posedge clk);
      bus.re   <= 1'h1;
      bus.addr <= a;
      @(posedge clk);
      bus.re   <= 1'h0;
      #1;
      v = rdata;
   endtask

   // Launch an operation and count edges until its done interrupt, bounded
   task automatic run_op(input logic [7:0] op, output int cnt);
      wr(A_CTRL, 32'(op));
      cnt = 0;
      #1;
      while (irq !== 1'h1 && cnt < 20) begin
         @(posedge clk);
         #1;
         cnt++;
      end
      wr(A_ISTAT, 32'hf);
   endtask

   task automatic end_of_test();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Watchdog: the run needs well under 2000 cycles
   initial begin
      #100000;
      failures++;
      end_of_test();
   end

   // ***************************************************************
   // Scenarios
   // ***************************************************************
   initial begin
      clk = 1'h0; rst = 1'h1; pwr_rst = 1'h1; bus = '0; bsel = 1'h1; ev = 1'h0;
      failures = 0; checks = 0; nwr = 0;
      repeat (3) @(posedge clk);
      #1;
      chk(32'({pri, lack, fetch, mwe}), 32'h40);
      @(posedge clk);
      rst <= 1'h0;      // Clock has run throughout the reset
      pwr_rst <= 1'h0;  // No bus request while reset is high
      repeat (3) @(posedge clk);
      bsel <= 1'h0;  // Late change of the select pin must be ignored
      repeat (3) @(posedge clk);
      rd(A_STAT, d);
      chk(d, 32'h3e0);
      rd(A_IPTR, d);
      chk(d, 32'h7ffe);
      rd(A_WPTR, d);
      chk(d, 32'(FF));
      rd(8'h20, d);
      chk(d, 32'h0);
      // Operation table: cycle counts, error flag, test results
      wr(A_IMASK, 32'h4);
      foreach (rows[i]) begin
         wr(A_OPND, rows[i].opnd);
         run_op(rows[i].op, n);
         chk(32'(n), 32'(rows[i].cyc));
         chk(32'(err), 32'(rows[i].err));
         if (rows[i].res[1]) begin
            rd(A_RES, d);
            chk(d, 32'(rows[i].res[0]));
         end
      end
      // Masked event stays silent, unmasking raises the line, clearing drops it
      wr(A_IMASK, 32'h0);
      @(posedge clk);
      ev <= 1'h1;
      repeat (4) @(posedge clk);
      #1;
      chk(32'(irq), 32'h0);
      rd(A_ISTAT, d);
      chk(32'(d[3]), 32'h1);
      wr(A_IMASK, 32'h8);
      ev <= 1'h0;
      @(posedge clk);
      #1;
      chk(32'(irq), 32'h1);
      wr(A_ISTAT, 32'hf);
      @(posedge clk);
      #1;
      chk(32'(irq), 32'h0);
      // Halt when faulted, then a device reset that must keep the error flag
      wr(A_IMASK, 32'h4);
      run_op(OP_SETHALT, n);
      run_op(OP_SETERR, n);
      chk(32'({halted, fetch, err}), 32'h5);
      @(posedge clk);
      rst <= 1'h1;
      repeat (4) @(posedge clk);
      #1;
      chk(32'({err, halted, lack}), 32'h20);
      @(posedge clk);
      rst <= 1'h0;
      repeat (3) @(posedge clk);
      #1;
      chk(32'(fetch), 32'h0);
      nwr = 0;
      i_rbec_link_host.send(8'h02, 2);
      repeat (3) @(posedge clk);
      #1;
      chk(32'({fetch, err}), 32'h3);
      chk(32'(nwr), 32'h2);
      chk(32'({last_a, last_d}), {FF + 16'h1, 8'ha1});
      rd(A_IPTR, d);
      chk(d, 32'(FF));
      rd(A_WPTR, d);
      chk(d, 32'(FF + 16'h2));
      wr(A_IMASK, 32'h4);  // Reset cleared the mask; the done event paces run_op
      run_op(OP_TESTERR, n);
      chk(32'({n[3:0], err}), 32'h6);
      end_of_test();
   end
endmodule // rbec_ctrl_tb
